// ===== src/wpm_filter.sv
// Wake input synchroniser and glitch filter.
// Assumes the raw input is asynchronous and held quiet while disabled.
`timescale 1ns/1ps

module wpm_filter
(
	input wire logic clock,
	input wire logic reset,
	input wire logic raw_in,
	input wire logic hold_off,
	output wpm_pkg::wpm_filt_t filt
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		wpm_pkg::wpm_fstate_t fs;
		logic [wpm_pkg::CNT_W-1:0] cnt;
		wpm_pkg::wpm_filt_t out;
	} wpm_fil_state_t;

	wpm_fil_state_t st_r;
	wpm_fil_state_t st_nxt;

	// Next state: count while the sampled level differs from the stable one
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sync1 = raw_in;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.out.rise = 1'b0;
		st_nxt.out.fall = 1'b0;
		if (hold_off)
		begin
			st_nxt.fs = wpm_pkg::WPM_F_STABLE;
			st_nxt.cnt = wpm_pkg::CNT_ZERO;
		end
		else if (st_r.sync2 == st_r.out.level)
		begin
			st_nxt.fs = wpm_pkg::WPM_F_STABLE;
			st_nxt.cnt = wpm_pkg::CNT_ZERO;
		end
		else
		begin
			case (st_r.fs)
				wpm_pkg::WPM_F_STABLE:
				begin
					st_nxt.fs = wpm_pkg::WPM_F_COUNT;
					st_nxt.cnt = wpm_pkg::CNT_ONE;
				end
				wpm_pkg::WPM_F_COUNT:
				begin
					if (st_r.cnt >= wpm_pkg::FILTER_CYCLES)
					begin
						st_nxt.fs = wpm_pkg::WPM_F_STABLE;
						st_nxt.cnt = wpm_pkg::CNT_ZERO;
						st_nxt.out.level = st_r.sync2;
						st_nxt.out.rise = st_r.sync2;
						st_nxt.out.fall = ~st_r.sync2;
					end
					else
						st_nxt.cnt = st_r.cnt + wpm_pkg::CNT_ONE;
				end
				default:
				begin
					st_nxt.fs = wpm_pkg::WPM_F_STABLE;
					st_nxt.cnt = wpm_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign filt = st_r.out;

endmodule // wpm_filter

// ===== src/wpm_monitor.sv
// Wake pin monitor top: filtered wake input, edge flags, mode wake requests.
// Assumes the mode controller drives device_mode and acts on the wake pulses.
//
// Functional notes
// - Both input edge polarities are wake events
// - Change counts only after filter time passes
// - Host enable bit gates wake detection, except the Fail-Safe restart
// - Below undervoltage level, input off, events dropped
// - Pin level readable in Normal, Stop, Flash
// - Enabled filtered change wakes device from Sleep
// - Fail-Safe filtered change always requests Restart
// - Active modes set edge flags, interrupt unless masked
// - Rising and falling interrupts masked independently
// - Normal to Sleep blocked while flags set
// - Flag set at Sleep entry causes re-wake
`timescale 1ns/1ps

module wpm_monitor
(
	input wire logic clock,
	input wire logic reset,
	input wire logic wake_input,
	input wire logic undervoltage_off,
	input wire wpm_pkg::wpm_mode_t device_mode,
	input wire logic wake_input_enable,
	input wire wpm_pkg::wpm_flags_t flag_mask,
	input wire wpm_pkg::wpm_flags_t flag_clear,
	input wire logic sleep_request,
	output logic wake_input_oe,
	output logic wake_level_status,
	output wpm_pkg::wpm_flags_t pin_wake_flags,
	output logic wake_irq,
	output logic sleep_wake,
	output logic restart_request,
	output logic sleep_refused
);

	typedef struct packed {
		logic level_status;
		wpm_pkg::wpm_flags_t flags;
		logic irq;
		logic sleep_wake;
		logic restart;
		logic refused;
		logic rewake_pending;
	} wpm_top_state_t;

	wpm_top_state_t st_r;
	wpm_top_state_t st_nxt;
	wpm_pkg::wpm_filt_t filt;
	logic active_mode;
	logic rise_ev;
	logic fall_ev;
	logic flags_any;

	// Synchroniser and filter; held off below undervoltage level
	wpm_filter u_filter
	(
		.clock(clock),
		.reset(reset),
		.raw_in(wake_input),
		.hold_off(undervoltage_off),
		.filt(filt)
	);

	// Event qualification
	always_comb
	begin
		active_mode = (device_mode == wpm_pkg::WPM_MODE_NORMAL)
			|| (device_mode == wpm_pkg::WPM_MODE_STOP)
			|| (device_mode == wpm_pkg::WPM_MODE_FLASH);
		rise_ev = filt.rise & ~undervoltage_off;
		fall_ev = filt.fall & ~undervoltage_off;
		flags_any = st_r.flags.a | st_r.flags.b;
	end

	// Next state of flags, requests and status
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sleep_wake = 1'b0;
		st_nxt.restart = 1'b0;
		st_nxt.refused = 1'b0;
		// Level status tracks the filtered pin in the active modes
		if (active_mode)
			st_nxt.level_status = filt.level;
		// Clear first so that a same-cycle set wins
		if (flag_clear.a)
			st_nxt.flags.a = 1'b0;
		if (flag_clear.b)
			st_nxt.flags.b = 1'b0;
		if (wake_input_enable && active_mode)
		begin
			if (rise_ev)
				st_nxt.flags.a = 1'b1;
			if (fall_ev)
				st_nxt.flags.b = 1'b1;
		end
		// Sleep command with flags pending is refused, re-wake armed
		// Only an enabled change would set a flag, so of same-cycle changes only that can refuse
		if (sleep_request && device_mode == wpm_pkg::WPM_MODE_NORMAL)
		begin
			if (flags_any || (wake_input_enable && (rise_ev || fall_ev)))
			begin
				st_nxt.refused = 1'b1;
				st_nxt.rewake_pending = 1'b1;
			end
			else
				st_nxt.rewake_pending = 1'b0; // Clean command drops a stale re-wake
		end
		// Sleep: enabled change or pending flags wake the device
		if (device_mode == wpm_pkg::WPM_MODE_SLEEP)
		begin
			if ((wake_input_enable && (rise_ev || fall_ev))
				|| st_r.rewake_pending || flags_any)
			begin
				st_nxt.sleep_wake = 1'b1;
				st_nxt.rewake_pending = 1'b0;
			end
		end
		else if (device_mode != wpm_pkg::WPM_MODE_NORMAL)
			st_nxt.rewake_pending = 1'b0;
		// Fail-Safe always restarts on a filtered change
		if (device_mode == wpm_pkg::WPM_MODE_FAILSAFE && (rise_ev || fall_ev))
			st_nxt.restart = 1'b1;
		// Per-edge masking of the interrupt
		st_nxt.irq = (st_nxt.flags.a & ~flag_mask.a)
			| (st_nxt.flags.b & ~flag_mask.b);
	end

	// State register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Input stays high impedance: the block never drives the pin
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			wake_input_oe <= 1'b0;
		else
			wake_input_oe <= 1'b0;
	end

	assign wake_level_status = st_r.level_status;
	assign pin_wake_flags = st_r.flags;
	assign wake_irq = st_r.irq;
	assign sleep_wake = st_r.sleep_wake;
	assign restart_request = st_r.restart;
	assign sleep_refused = st_r.refused;

endmodule // wpm_monitor

// ===== src/wpm_pkg.sv
// Package for the wake pin monitor: mode codes, carriers, filter timing.
// Assumes a 20 MHz system clock; all users refer to names as wpm_pkg::name.
package wpm_pkg;

	// Clock rate and filter timing
	localparam int CLOCK_HZ = 20000000;
	localparam int FILTER_MIN_US = 10;
	localparam int FILTER_MAX_US = 25;
	// Aim at the middle of the window so tolerance stays inside it
	localparam int FILTER_US = (FILTER_MIN_US + FILTER_MAX_US) / 2;
	localparam int FILTER_CYCLES_I = (FILTER_US * (CLOCK_HZ / 1000000));
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] FILTER_CYCLES = CNT_W'(FILTER_CYCLES_I);
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

	// Device operating modes as seen by this block
	typedef enum logic [2:0] {
		WPM_MODE_OFF = 3'h0,
		WPM_MODE_NORMAL = 3'h1,
		WPM_MODE_STOP = 3'h2,
		WPM_MODE_FLASH = 3'h3,
		WPM_MODE_SLEEP = 3'h4,
		WPM_MODE_FAILSAFE = 3'h5,
		WPM_MODE_RESTART = 3'h6,
		WPM_MODE_INIT = 3'h7
	} wpm_mode_t;

	// Filter state, Gray coded along idle -> counting -> idle
	typedef enum logic [1:0] {
		WPM_F_STABLE = 2'h0,
		WPM_F_COUNT = 2'h1
	} wpm_fstate_t;

	// Filter outputs: stable level and one-cycle edge pulses
	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} wpm_filt_t;

	// Flag pair: a holds rising, b holds falling
	typedef struct packed {
		logic a;
		logic b;
	} wpm_flags_t;

	localparam logic RESET_LEVEL = 1'b0;

endpackage

// ===== tb/wpm_monitor_properties.sv
// Port checker for the wake pin monitor.
// Assumes it is bound onto wpm_monitor.
`timescale 1ns/1ps
module wpm_chk
(
	input wire logic clock,
	input wire logic reset,
	input wire logic undervoltage_off,
	input wire logic wake_input_enable,
	input wire wpm_pkg::wpm_mode_t device_mode,
	input wire wpm_pkg::wpm_flags_t flag_mask,
	input wire wpm_pkg::wpm_flags_t flag_clear,
	input wire logic sleep_request,
	input wire logic wake_input_oe,
	input wire logic wake_level_status,
	input wire wpm_pkg::wpm_flags_t pin_wake_flags,
	input wire logic wake_irq,
	input wire logic sleep_wake,
	input wire logic restart_request,
	input wire logic sleep_refused
);
	logic act_m;
	logic flags_on;
	// Helpers: an active mode, and any edge flag set
	assign act_m = (device_mode == wpm_pkg::WPM_MODE_NORMAL)
		|| (device_mode == wpm_pkg::WPM_MODE_STOP)
		|| (device_mode == wpm_pkg::WPM_MODE_FLASH);
	assign flags_on = pin_wake_flags.a | pin_wake_flags.b;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Relations between causes and outputs
	oe_off_a: assert property (!wake_input_oe)
		else $error("pin driven");
	irq_src_a: assert property (wake_irq |-> flags_on)
		else $error("irq without flag");
	irq_mask_a: assert property (
		wake_irq == ((pin_wake_flags.a & ~$past(flag_mask.a))
		| (pin_wake_flags.b & ~$past(flag_mask.b))))
		else $error("irq mask mismatch");
	flag_hold_a: assert property (
		pin_wake_flags.a && !flag_clear.a |=> pin_wake_flags.a)
		else $error("flag lost");
	en_gate_a: assert property ($rose(pin_wake_flags.a) |-> $past(wake_input_enable))
		else $error("flag while disabled");
	act_mode_a: assert property ($rose(pin_wake_flags.b) |-> $past(act_m))
		else $error("flag in idle mode");
	uv_drop_a: assert property ($rose(pin_wake_flags.a) |-> !$past(undervoltage_off))
		else $error("flag below supply limit");
	rise_lvl_a: assert property ($rose(pin_wake_flags.a) |-> wake_level_status)
		else $error("rising flag with low level");
	fall_lvl_a: assert property ($rose(pin_wake_flags.b) |-> !wake_level_status)
		else $error("falling flag with high level");
	sleep_ref_a: assert property (
		sleep_refused |-> $past(sleep_request) && ($past(flags_on) || flags_on))
		else $error("bad refusal");
	sleep_blk_a: assert property (
		sleep_request && device_mode == wpm_pkg::WPM_MODE_NORMAL && flags_on
		|=> sleep_refused)
		else $error("sleep not refused");
	fs_restart_a: assert property (
		restart_request |-> $past(device_mode) == wpm_pkg::WPM_MODE_FAILSAFE)
		else $error("restart outside fail-safe");
	sleep_wk_a: assert property (
		sleep_wake |-> $past(device_mode) == wpm_pkg::WPM_MODE_SLEEP)
		else $error("wake outside sleep");
	sleep_rewake_a: assert property (
		device_mode == wpm_pkg::WPM_MODE_SLEEP && flags_on |=> sleep_wake)
		else $error("no re-wake with flag set");
	lvl_hold_a: assert property (!act_m |=> $stable(wake_level_status))
		else $error("status moved");
endmodule // wpm_chk
bind wpm_monitor wpm_chk u_chk
(
	.clock(clock),
	.reset(reset),
	.undervoltage_off(undervoltage_off),
	.wake_input_enable(wake_input_enable),
	.device_mode(device_mode),
	.flag_mask(flag_mask),
	.flag_clear(flag_clear),
	.sleep_request(sleep_request),
	.wake_input_oe(wake_input_oe),
	.wake_level_status(wake_level_status),
	.pin_wake_flags(pin_wake_flags),
	.wake_irq(wake_irq),
	.sleep_wake(sleep_wake),
	.restart_request(restart_request),
	.sleep_refused(sleep_refused)
);

// ===== tb/wpm_monitor_tb.sv
// Self-checking bench for the wake pin monitor.
// Assumes the wake line model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t %h %h", $time, a, e); end end
module wpm_monitor_tb;
	logic clock = 1'b0, reset = 1'b1, lvl = 1'b0, uv = 1'b0, en = 1'b1, req = 1'b0;
	logic pin, oe, st, irq, sw, rr, sr;
	logic sw_s = 1'b0, rr_s = 1'b0, sr_s = 1'b0;
	wpm_pkg::wpm_mode_t mode = wpm_pkg::WPM_MODE_NORMAL;
	wpm_pkg::wpm_flags_t msk = 2'h0, clr = 2'h0, fl;
	int errors = 0, checked = 0;
	// Clock, 50 ns period
	initial
	begin
		forever #25 clock = ~clock;
	end
	wpm_wake_src u_src (.clock(clock), .lvl(lvl), .pin(pin));
	wpm_monitor u_dut (.clock(clock), .reset(reset), .wake_input(pin), .undervoltage_off(uv),
		.device_mode(mode), .wake_input_enable(en), .flag_mask(msk), .flag_clear(clr),
		.sleep_request(req), .wake_input_oe(oe), .wake_level_status(st), .pin_wake_flags(fl),
		.wake_irq(irq), .sleep_wake(sw), .restart_request(rr), .sleep_refused(sr));
	// Catch the one-cycle pulses
	always @(posedge clock)
	begin
		if (sw) sw_s <= 1'b1;
		if (rr) rr_s <= 1'b1;
		if (sr) sr_s <= 1'b1;
	end
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Move the pin and hold it
	task automatic step(logic v, int n);
		{sw_s, rr_s, sr_s} = 3'h0;
		lvl = v;
		tick(n);
	endtask
	task automatic clear;
		clr = 2'h3;
		tick(1);
		clr = 2'h0;
	endtask
	task automatic t_edges;
		step(1'b1, 400);
		`CHK({fl, irq, st}, 4'hB)
		clear;
		step(1'b0, 400);
		`CHK({fl, st}, 3'h2)
		clear;
	endtask
	// Short pulses, and a long change broken by a short return
	task automatic t_glitch;
		step(1'b1, 100);
		step(1'b0, 400);
		`CHK(fl, 2'h0)
		step(1'b1, 300);
		step(1'b0, 20);
		step(1'b1, 300);
		`CHK(fl, 2'h0)
		step(1'b0, 400);
		`CHK(fl, 2'h0)
	endtask
	// Each edge masked on its own
	task automatic t_mask;
		msk = 2'h2;
		step(1'b1, 400);
		`CHK({fl, irq}, 3'h4)
		clear;
		msk = 2'h1;
		step(1'b0, 400);
		`CHK({fl, irq}, 3'h2)
		msk = 2'h2;
		tick(2);
		`CHK(irq, 1'b1)
		clear;
		msk = 2'h0;
	endtask
	task automatic t_off;
		en = 1'b0;
		step(1'b1, 400);
		step(1'b0, 400);
		`CHK(fl, 2'h0)
		en = 1'b1;
		uv = 1'b1;
		step(1'b1, 400);
		`CHK({fl, st, oe}, 4'h0)
		step(1'b0, 20);
		uv = 1'b0;
		tick(400);
		`CHK(fl, 2'h0)
	endtask
	task automatic t_sleep;
		{sw_s, rr_s, sr_s} = 3'h0;
		req = 1'b1;
		tick(1);
		req = 1'b0;
		tick(3);
		`CHK(sr_s, 1'b0)
		step(1'b1, 400);
		req = 1'b1;
		tick(1);
		req = 1'b0;
		tick(3);
		`CHK(sr_s, 1'b1)
		mode = wpm_pkg::WPM_MODE_SLEEP;
		tick(3);
		`CHK(sw_s, 1'b1)
		clear;
		tick(2);
		step(1'b0, 400);
		`CHK({sw_s, fl}, 3'h4)
		`CHK(st, 1'b1)
		en = 1'b0;
		step(1'b1, 400);
		`CHK(sw_s, 1'b0)
		mode = wpm_pkg::WPM_MODE_FAILSAFE;
		step(1'b0, 400);
		`CHK(rr_s, 1'b1)
		en = 1'b1;
	endtask
	task automatic summarize;
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		tick(5);
		reset = 1'b0;
		tick(2);
		t_edges;
		t_glitch;
		t_mask;
		t_off;
		t_sleep;
		summarize;
	end
	// Watchdog
	initial
	begin
		#1000000;
		errors++;
		summarize;
	end
endmodule // wpm_monitor_tb

// ===== tb/wpm_wake_src.sv
// Model of the external wake line feeding the monitor.
// Assumes the bench sets the wanted line level on lvl; each change chatters briefly.
`timescale 1ns/1ps
module wpm_wake_src
(
	input wire logic clock,
	input wire logic lvl,
	output logic pin
);
	logic pin_r = 1'b0;
	logic last_r = 1'b0;
	logic [2:0] bnc_r = 3'h0;
	// A switch contact chatters for a few cycles before it settles
	always @(posedge clock)
	begin
		if (lvl != last_r)
		begin
			last_r <= lvl;
			bnc_r <= 3'h6;
			pin_r <= lvl;
		end
		else if (bnc_r != 3'h0)
		begin
			bnc_r <= bnc_r - 3'h1;
			pin_r <= ~pin_r;
		end
		else
			pin_r <= last_r;
	end
	assign pin = pin_r;
endmodule // wpm_wake_src
